// ==== src/timer_pkg.sv ====
// constants, register map and types for the timer clock and waveform block
//
// Function
// - timer source is the system clock after reset, the oscillator pin when async is set
// - async select detaches both oscillator pins from their port function
// - external clock enable accepts a driven clock on the oscillator input pin
// - prescaler offers source divided by 8, 32, 64, 128, 256, 1024, undivided or stop
// - writing one to the prescaler reset bit clears the prescaler
// - nonzero compare mode lets the compare output override the port pin
// - non-PWM modes: 00 off, 01 toggle, 10 clear, 11 set on match
// - fast PWM channel A: 10 clear/set at bottom, 11 inverse, 01 toggle if mode bit
// - fast PWM channel B: 01 reserved, 10 non-inverting, 11 inverting
// - fast PWM: compare equal to top with high mode bit ignores the match
// - phase correct channel A: 10 clear up set down, 11 opposite, 01 toggle if bit
// - phase correct channel B: 01 reserved, 10 clear up set down, 11 opposite
// - phase correct: compare equal to top with high mode bit acts at top
// - control A bits 3:2 are reserved, ignore writes and read zero
// - two low mode bits plus the high bit form a three-bit waveform mode
// - modes 0, 1, 3 use top 0xff with their update and overflow points
// - modes 2, 5, 7 use compare A as top; modes 4 and 6 reserved
// - clock select 000 stop, 001 undivided, 010 to 111 the six divided clocks
// - each compare value is compared continuously with the counter
package timer_pkg;
	// ************************************************************
	// register map (byte addresses)
	// ************************************************************
	localparam logic [7:0] ADDR_CTRL_A = 8'hb0;
	localparam logic [7:0] ADDR_CTRL_B = 8'hb1;
	localparam logic [7:0] ADDR_COUNT = 8'hb2;
	localparam logic [7:0] ADDR_CMP_A = 8'hb3;
	localparam logic [7:0] ADDR_CMP_B = 8'hb4;
	localparam logic [7:0] ADDR_ASYNC = 8'hb6;
	localparam logic [7:0] ADDR_GEN = 8'hc0;
	localparam logic [7:0] RESET_VAL = 8'h00;
	localparam logic [7:0] CTRL_A_MASK = 8'hf3;
	localparam logic [7:0] CTRL_B_MASK = 8'h0f;
	localparam logic [7:0] ASYNC_MASK = 8'h60;
	localparam int BIT_EXT_CLK = 6;
	localparam int BIT_ASYNC = 5;
	localparam int BIT_PSR = 1;
	localparam int BIT_MODE_HI = 3;
	localparam logic [7:0] VAL_MAX = 8'hff;
	localparam logic [7:0] VAL_BOTTOM = 8'h00;
	localparam int PRESCALE_W = 10;
	localparam int PS_TAP_8 = 2;
	localparam int PS_TAP_32 = 4;
	localparam int PS_TAP_64 = 5;
	localparam int PS_TAP_128 = 6;
	localparam int PS_TAP_256 = 7;
	localparam int PS_TAP_1024 = 9;

	// ************************************************************
	// encodings
	// ************************************************************
	localparam logic [1:0] COM_OFF = 2'h0;
	localparam logic [1:0] COM_TOGGLE = 2'h1;
	localparam logic [1:0] COM_CLEAR = 2'h2;
	localparam logic [1:0] COM_SET = 2'h3;
	localparam logic [2:0] WM_NORMAL = 3'h0;
	localparam logic [2:0] WM_PC_FF = 3'h1;
	localparam logic [2:0] WM_CTC = 3'h2;
	localparam logic [2:0] WM_FAST_FF = 3'h3;
	localparam logic [2:0] WM_PC_CMP = 3'h5;
	localparam logic [2:0] WM_FAST_CMP = 3'h7;

	typedef enum logic [2:0] {
		KIND_NONPWM = 3'b001,
		KIND_FAST = 3'b010,
		KIND_PHASE = 3'b100
	} wave_kind_type;
endpackage

// ==== src/tick_if.sv ====
// timer tick carried from the prescaler to the counter
`timescale 1ns/10ps
interface tick_if;
	logic tick;
	logic src_clk_sel;
	logic [2:0] clk_sel;
	logic psr_clear;
	modport source (output tick, input src_clk_sel, input clk_sel, input psr_clear);
	modport sink (input tick, output src_clk_sel, output clk_sel, output psr_clear);
endinterface

// ==== src/timer_prescaler.sv ====
// prescaler: source clock select and divided timer tick
`timescale 1ns/10ps
module timer_prescaler (
	input wire logic clk_i,
	input wire logic rstn_i,
	input wire logic osc_in_pin_i,
	tick_if.source tk
);
	logic osc_s1_ff;
	logic osc_s2_ff;
	logic osc_s3_ff;
	logic src_tick;
	logic [timer_pkg::PRESCALE_W-1:0] div_ff;
	logic [timer_pkg::PRESCALE_W-1:0] nxt_div;
	logic tick_ff;
	logic sel_tap;

	// oscillator pin is sampled; the rising edge is one source tick
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			osc_s1_ff <= 1'b0;
			osc_s2_ff <= 1'b0;
			osc_s3_ff <= 1'b0;
		end else begin
			osc_s1_ff <= osc_in_pin_i;
			osc_s2_ff <= osc_s1_ff;
			osc_s3_ff <= osc_s2_ff;
		end
	end

	// system clock by default, oscillator edges when async is selected
	assign src_tick = tk.src_clk_sel ? (osc_s2_ff & ~osc_s3_ff) : 1'b1;

	assign nxt_div = div_ff + {{(timer_pkg::PRESCALE_W-1){1'b0}}, 1'b1};

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			div_ff <= '0;
		end else if (tk.psr_clear) begin
			div_ff <= '0;
		end else if (src_tick) begin
			div_ff <= nxt_div;
		end
	end

	// a tap fires when all bits below and including it roll to zero next
	always_comb begin
		case (tk.clk_sel)
			3'h0: sel_tap = 1'b0;
			3'h1: sel_tap = 1'b1;
			3'h2: sel_tap = &div_ff[timer_pkg::PS_TAP_8:0];
			3'h3: sel_tap = &div_ff[timer_pkg::PS_TAP_32:0];
			3'h4: sel_tap = &div_ff[timer_pkg::PS_TAP_64:0];
			3'h5: sel_tap = &div_ff[timer_pkg::PS_TAP_128:0];
			3'h6: sel_tap = &div_ff[timer_pkg::PS_TAP_256:0];
			default: sel_tap = &div_ff[timer_pkg::PS_TAP_1024:0];
		endcase
	end

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			tick_ff <= 1'b0;
		end else begin
			tick_ff <= src_tick & sel_tap & ~tk.psr_clear;
		end
	end

	assign tk.tick = tick_ff;
endmodule

// ==== src/timer_wave_ctl.sv ====
// timer control registers over apb, counter, compare and waveform outputs
//
// Chosen here: the APB slave port.
`timescale 1ns/10ps
module timer_wave_ctl (
	input wire logic clk_i,
	input wire logic rstn_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [31:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	input wire logic [3:0] pstrb_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	input wire logic osc_in_pin_i,
	output logic osc_pins_detach_o,
	output logic osc_ext_clock_o,
	output logic compare_out_a_o,
	output logic compare_out_b_o,
	output logic out_a_override_o,
	output logic out_b_override_o,
	output logic overflow_flag_o,
	output logic match_a_o,
	output logic match_b_o
);
	// ************************************************************
	// registers
	// ************************************************************
	logic [7:0] ctrl_a_ff;
	logic [7:0] ctrl_b_ff;
	logic [7:0] async_ff;
	logic [7:0] counter_value_ff;
	logic [7:0] compare_value_a_ff;
	logic [7:0] compare_value_b_ff;
	logic [7:0] cmp_a_buf_ff;
	logic [7:0] cmp_b_buf_ff;
	logic count_down_ff;
	logic out_a_ff;
	logic out_b_ff;
	logic ovf_ff;
	logic hit_a_ff;
	logic hit_b_ff;
	logic [31:0] prdata_ff;
	logic [7:0] waddr;
	logic wr_en;
	logic rd_en;
	logic addr_ok;
	logic psr_wr;
	logic [7:0] rd_val;

	// ************************************************************
	// mode decode
	// ************************************************************
	logic [2:0] waveform_mode;
	logic [1:0] out_a_compare_mode;
	logic [1:0] out_b_compare_mode;
	logic [2:0] clock_select_field;
	timer_pkg::wave_kind_type kind;
	logic top_is_cmp;
	logic [7:0] top_val;
	logic at_top;
	logic at_bottom;
	logic tick;
	logic match_a;
	logic match_b;
	logic [7:0] nxt_count;
	logic nxt_down;
	logic upd_now;
	logic ovf_now;

	tick_if tk ();

	timer_prescaler u_prescaler (
		.clk_i(clk_i),
		.rstn_i(rstn_i),
		.osc_in_pin_i(osc_in_pin_i),
		.tk(tk)
	);

	assign waveform_mode = {ctrl_b_ff[timer_pkg::BIT_MODE_HI], ctrl_a_ff[1:0]};
	assign out_a_compare_mode = ctrl_a_ff[7:6];
	assign out_b_compare_mode = ctrl_a_ff[5:4];
	assign clock_select_field = ctrl_b_ff[2:0];

	assign tk.src_clk_sel = async_ff[timer_pkg::BIT_ASYNC];
	assign tk.clk_sel = clock_select_field;
	assign tk.psr_clear = psr_wr;
	assign tick = tk.tick;

	// reserved modes 4 and 6 behave as normal counting
	always_comb begin
		case (waveform_mode)
			timer_pkg::WM_PC_FF: kind = timer_pkg::KIND_PHASE;
			timer_pkg::WM_PC_CMP: kind = timer_pkg::KIND_PHASE;
			timer_pkg::WM_FAST_FF: kind = timer_pkg::KIND_FAST;
			timer_pkg::WM_FAST_CMP: kind = timer_pkg::KIND_FAST;
			default: kind = timer_pkg::KIND_NONPWM;
		endcase
	end

	assign top_is_cmp = (waveform_mode == timer_pkg::WM_CTC) ||
		(waveform_mode == timer_pkg::WM_PC_CMP) ||
		(waveform_mode == timer_pkg::WM_FAST_CMP);
	assign top_val = top_is_cmp ? compare_value_a_ff : timer_pkg::VAL_MAX;
	assign at_top = (counter_value_ff == top_val);
	assign at_bottom = (counter_value_ff == timer_pkg::VAL_BOTTOM);
	assign match_a = (counter_value_ff == compare_value_a_ff);
	assign match_b = (counter_value_ff == compare_value_b_ff);

	assign osc_pins_detach_o = async_ff[timer_pkg::BIT_ASYNC];
	assign osc_ext_clock_o = async_ff[timer_pkg::BIT_ASYNC] &
		async_ff[timer_pkg::BIT_EXT_CLK];
	assign out_a_override_o = |out_a_compare_mode;
	assign out_b_override_o = |out_b_compare_mode;

	// ************************************************************
	// apb slave, zero wait states
	// ************************************************************
	assign waddr = paddr_i[7:0];
	assign wr_en = psel_i & penable_i & pwrite_i & pstrb_i[0];
	assign rd_en = psel_i & penable_i & ~pwrite_i;
	assign pready_o = 1'b1;
	assign psr_wr = wr_en && addr_ok && (waddr == timer_pkg::ADDR_GEN) &&
		pwdata_i[timer_pkg::BIT_PSR];

	always_comb begin
		addr_ok = (paddr_i[31:8] == 24'h000000);
		if (waddr == timer_pkg::ADDR_CTRL_A) begin
			rd_val = ctrl_a_ff;
		end else if (waddr == timer_pkg::ADDR_CTRL_B) begin
			rd_val = ctrl_b_ff;
		end else if (waddr == timer_pkg::ADDR_COUNT) begin
			rd_val = counter_value_ff;
		end else if (waddr == timer_pkg::ADDR_CMP_A) begin
			rd_val = cmp_a_buf_ff;
		end else if (waddr == timer_pkg::ADDR_CMP_B) begin
			rd_val = cmp_b_buf_ff;
		end else if (waddr == timer_pkg::ADDR_ASYNC) begin
			rd_val = async_ff;
		end else if (waddr == timer_pkg::ADDR_GEN) begin
			rd_val = timer_pkg::RESET_VAL;
		end else begin
			rd_val = timer_pkg::RESET_VAL;
			addr_ok = 1'b0;
		end
	end

	assign pslverr_o = psel_i & penable_i & ~addr_ok;

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			prdata_ff <= '0;
		end else if (psel_i & ~penable_i & ~pwrite_i) begin
			prdata_ff <= {24'h000000, rd_val};
		end
	end
	assign prdata_o = rd_en ? prdata_ff : 32'h00000000;

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			ctrl_a_ff <= timer_pkg::RESET_VAL;
			ctrl_b_ff <= timer_pkg::RESET_VAL;
			async_ff <= timer_pkg::RESET_VAL;
			cmp_a_buf_ff <= timer_pkg::RESET_VAL;
			cmp_b_buf_ff <= timer_pkg::RESET_VAL;
		end else if (wr_en && addr_ok) begin
			if (waddr == timer_pkg::ADDR_CTRL_A) begin
				ctrl_a_ff <= pwdata_i[7:0] & timer_pkg::CTRL_A_MASK;
			end else if (waddr == timer_pkg::ADDR_CTRL_B) begin
				ctrl_b_ff <= pwdata_i[7:0] & timer_pkg::CTRL_B_MASK;
			end else if (waddr == timer_pkg::ADDR_CMP_A) begin
				cmp_a_buf_ff <= pwdata_i[7:0];
			end else if (waddr == timer_pkg::ADDR_CMP_B) begin
				cmp_b_buf_ff <= pwdata_i[7:0];
			end else if (waddr == timer_pkg::ADDR_ASYNC) begin
				async_ff <= pwdata_i[7:0] & timer_pkg::ASYNC_MASK;
			end
		end
	end

	// ************************************************************
	// compare register update point
	// ************************************************************
	always_comb begin
		case (kind)
			timer_pkg::KIND_PHASE: upd_now = tick & at_top;
			timer_pkg::KIND_FAST: upd_now = tick & at_bottom;
			default: upd_now = 1'b1;
		endcase
	end

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			compare_value_a_ff <= timer_pkg::RESET_VAL;
			compare_value_b_ff <= timer_pkg::RESET_VAL;
		end else if (upd_now) begin
			compare_value_a_ff <= cmp_a_buf_ff;
			compare_value_b_ff <= cmp_b_buf_ff;
		end
	end

	// ************************************************************
	// counter
	// ************************************************************
	always_comb begin
		nxt_down = count_down_ff;
		nxt_count = counter_value_ff + 8'h01;
		case (kind)
			timer_pkg::KIND_PHASE: begin
				// turn at top and bottom so the direction of a match is known
				if (count_down_ff && at_bottom) begin
					nxt_down = 1'b0;
					nxt_count = counter_value_ff + 8'h01;
				end else if (!count_down_ff && at_top) begin
					nxt_down = 1'b1;
					nxt_count = counter_value_ff - 8'h01;
				end else if (count_down_ff) begin
					nxt_count = counter_value_ff - 8'h01;
				end
			end
			timer_pkg::KIND_FAST: begin
				nxt_down = 1'b0;
				if (at_top) begin
					nxt_count = timer_pkg::VAL_BOTTOM;
				end
			end
			default: begin
				nxt_down = 1'b0;
				if (top_is_cmp && at_top) begin
					nxt_count = timer_pkg::VAL_BOTTOM;
				end
			end
		endcase
	end

	always_comb begin
		case (kind)
			timer_pkg::KIND_PHASE: ovf_now = count_down_ff & at_bottom;
			timer_pkg::KIND_FAST: ovf_now = top_is_cmp ? at_top :
				(counter_value_ff == timer_pkg::VAL_MAX);
			default: ovf_now = (counter_value_ff == timer_pkg::VAL_MAX);
		endcase
	end

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			counter_value_ff <= timer_pkg::RESET_VAL;
			count_down_ff <= 1'b0;
		end else if (wr_en && addr_ok && (waddr == timer_pkg::ADDR_COUNT)) begin
			counter_value_ff <= pwdata_i[7:0];
		end else if (tick) begin
			counter_value_ff <= nxt_count;
			count_down_ff <= nxt_down;
		end
	end

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			ovf_ff <= 1'b0;
			hit_a_ff <= 1'b0;
			hit_b_ff <= 1'b0;
		end else begin
			ovf_ff <= tick & ovf_now;
			hit_a_ff <= tick & match_a;
			hit_b_ff <= tick & match_b;
		end
	end
	assign overflow_flag_o = ovf_ff;
	assign match_a_o = hit_a_ff;
	assign match_b_o = hit_b_ff;

	// ************************************************************
	// waveform outputs
	// ************************************************************
	function automatic logic wave_next(
		input logic cur,
		input logic [1:0] com,
		input timer_pkg::wave_kind_type k,
		input logic chan_a,
		input logic mode_hi,
		input logic hit,
		input logic cmp_at_top,
		input logic bot,
		input logic top,
		input logic down
	);
		logic r;
		logic hit_ok;
		r = cur;
		hit_ok = hit & ~(cmp_at_top & com[1] & (k != timer_pkg::KIND_NONPWM));
		case (k)
			timer_pkg::KIND_FAST: begin
				if (com == timer_pkg::COM_TOGGLE) begin
					if (chan_a && mode_hi && hit) r = ~cur;
				end else if (com[1]) begin
					// the bottom action lands as the count wraps from top, so a
					// compare of zero still gives a one-cycle pulse
					if (top) r = (com == timer_pkg::COM_CLEAR);
					else if (hit_ok) r = (com == timer_pkg::COM_SET);
				end
			end
			timer_pkg::KIND_PHASE: begin
				if (com == timer_pkg::COM_TOGGLE) begin
					if (chan_a && mode_hi && hit) r = ~cur;
				end else if (com[1]) begin
					// a compare at top holds the down-counting level; a match at
					// bottom counts as up-counting, so zero keeps the non-inverting output low
					if (cmp_at_top && top) r = (com == timer_pkg::COM_CLEAR);
					else if (hit_ok) r = (com == timer_pkg::COM_SET) ^ (down & ~bot);
				end
			end
			default: begin
				case (com)
					timer_pkg::COM_TOGGLE: if (hit) r = ~cur;
					timer_pkg::COM_CLEAR: if (hit) r = 1'b0;
					timer_pkg::COM_SET: if (hit) r = 1'b1;
					default: r = cur;
				endcase
			end
		endcase
		return r;
	endfunction

	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			out_a_ff <= 1'b0;
			out_b_ff <= 1'b0;
		end else if (tick) begin
			out_a_ff <= wave_next(out_a_ff, out_a_compare_mode, kind, 1'b1,
				waveform_mode[2], match_a, compare_value_a_ff == top_val,
				at_bottom, at_top, count_down_ff);
			out_b_ff <= wave_next(out_b_ff, out_b_compare_mode, kind, 1'b0,
				waveform_mode[2], match_b, compare_value_b_ff == top_val,
				at_bottom, at_top, count_down_ff);
		end
	end

	assign compare_out_a_o = out_a_ff & out_a_override_o;
	assign compare_out_b_o = out_b_ff & out_b_override_o;
endmodule

// ==== verification/timer_wave_ctl_assertions.sv ====
// port checker for the timer control and waveform block
`timescale 1ns/10ps
module timer_wave_ctl_assertions (
	input wire logic clk_i,
	input wire logic rstn_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [31:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	input wire logic [3:0] pstrb_i,
	input wire logic [31:0] prdata_o,
	input wire logic pready_o,
	input wire logic pslverr_o,
	input wire logic osc_pins_detach_o,
	input wire logic osc_ext_clock_o,
	input wire logic compare_out_a_o,
	input wire logic compare_out_b_o,
	input wire logic out_a_override_o,
	input wire logic out_b_override_o,
	input wire logic overflow_flag_o,
	input wire logic match_a_o,
	input wire logic match_b_o
);
	logic [7:0] ctl_a_ff, ctl_b_ff, asy_ff;
	logic [2:0] stop_ff, wm;
	logic acc, wr, mapped;
	assign acc = psel_i & penable_i & pready_o;
	assign wr = acc & pwrite_i & pstrb_i[0];
	assign wm = {ctl_b_ff[3], ctl_a_ff[1:0]};
	assign mapped = paddr_i inside {32'hb0, 32'hb1, 32'hb2, 32'hb3, 32'hb4, 32'hb6, 32'hc0};
	// ************************************************************
	// shadows rebuilt from bus traffic alone, never from the design
	// ************************************************************
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			ctl_a_ff <= 8'h00;
			ctl_b_ff <= 8'h00;
			asy_ff <= 8'h00;
		end else begin
			ctl_a_ff <= (wr && paddr_i == 32'hb0) ? pwdata_i[7:0] : ctl_a_ff;
			ctl_b_ff <= (wr && paddr_i == 32'hb1) ? pwdata_i[7:0] : ctl_b_ff;
			asy_ff <= (wr && paddr_i == 32'hb6) ? pwdata_i[7:0] : asy_ff;
		end
	end
	// cycles spent stopped; saturates so pipeline latency has drained
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			stop_ff <= 3'h0;
		end else begin
			stop_ff <= (ctl_b_ff[2:0] != 3'h0) ? 3'h0 : stop_ff + {2'h0, stop_ff != 3'h7};
		end
	end
	// ************************************************************
	// properties
	// ************************************************************
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rstn_i);
	property p_ready; psel_i |-> pready_o; endproperty
	a_ready: assert property (p_ready) else $error("ready low");
	property p_unmapped; acc && !mapped |-> pslverr_o && prdata_o == 32'h0; endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped access accepted");
	property p_rsvd; acc && !pwrite_i && paddr_i == 32'hb0 |-> prdata_o[3:2] == 2'h0; endproperty
	a_rsvd: assert property (p_rsvd) else $error("reserved bits nonzero");
	property p_ovr; out_a_override_o == (ctl_a_ff[7:6] != 2'h0)
		&& out_b_override_o == (ctl_a_ff[5:4] != 2'h0); endproperty
	a_ovr: assert property (p_ovr) else $error("override mismatch");
	property p_detach; osc_pins_detach_o == asy_ff[5]; endproperty
	a_detach: assert property (p_detach) else $error("pin detach mismatch");
	property p_ext; osc_ext_clock_o == (asy_ff[5] & asy_ff[6]); endproperty
	a_ext: assert property (p_ext) else $error("external clock mismatch");
	property p_stop; stop_ff == 3'h7 |-> !(overflow_flag_o || match_a_o || match_b_o); endproperty
	a_stop: assert property (p_stop) else $error("event while stopped");
	property p_off_a; ctl_a_ff[7:6] == 2'h0 |-> !compare_out_a_o; endproperty
	a_off_a: assert property (p_off_a) else $error("output a driven while off");
	property p_clr_a; wm == 3'h0 && ctl_a_ff[7:6] == 2'h2 && $stable(ctl_a_ff) && match_a_o
		|-> ##[0:2] !compare_out_a_o; endproperty
	a_clr_a: assert property (p_clr_a) else $error("output a not cleared");
	property p_set_b; wm == 3'h0 && ctl_a_ff[5:4] == 2'h3 && $stable(ctl_a_ff) && match_b_o
		|-> ##[0:2] compare_out_b_o; endproperty
	a_set_b: assert property (p_set_b) else $error("output b not set");
	c_match: cover property (match_a_o && match_b_o);
	c_ovf: cover property (overflow_flag_o);
	c_err: cover property (acc && pslverr_o);
endmodule

bind timer_wave_ctl timer_wave_ctl_assertions u_timer_wave_ctl_assertions (.clk_i, .rstn_i,
	.psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .pstrb_i, .prdata_o, .pready_o,
	.pslverr_o, .osc_pins_detach_o, .osc_ext_clock_o, .compare_out_a_o, .compare_out_b_o,
	.out_a_override_o, .out_b_override_o, .overflow_flag_o, .match_a_o, .match_b_o);

// ==== verification/timer_wave_ctl_tb.sv ====
// self-checking bench for the timer control and waveform block
`timescale 1ns/10ps
module timer_wave_ctl_tb;
	logic clk_i = 1'b0;
	logic rstn_i = 1'b0;
	logic psel_i = 1'b0;
	logic penable_i = 1'b0;
	logic pwrite_i = 1'b0;
	logic [31:0] paddr_i = 32'h0;
	logic [31:0] pwdata_i = 32'h0;
	logic [3:0] pstrb_i = 4'hf;
	logic osc_in_pin_i = 1'b0;
	logic [31:0] prdata_o, rd, v;
	logic pready_o, pslverr_o, osc_pins_detach_o, osc_ext_clock_o, compare_out_a_o, er;
	logic compare_out_b_o, out_a_override_o, out_b_override_o, overflow_flag_o;
	logic match_a_o, match_b_o;
	logic [31:0] seed = 32'h45;
	logic [7:0] d, ca, cb;
	logic [7:0] amap [7] = '{8'hb0, 8'hb3, 8'hb4, 8'hb6, 8'hc0, 8'hb2, 8'hb1};
	logic [7:0] avals [4] = '{8'h20, 8'h60, 8'h40, 8'h00};
	logic [7:0] pw [4] = '{8'ha3, 8'hf3, 8'ha1, 8'hf1};
	int dv [8] = '{0, 1, 8, 32, 64, 128, 256, 1024};
	int cnt [6] = '{0, 0, 0, 0, 0, 0};
	int d4 [6];
	int fails = 0;
	int n_tests = 0;
	int w, e;
	logic [1:0] last = 2'h0;
	logic [2:0] osc_cnt = 3'h0;

	timer_wave_ctl u_timer_wave_ctl (.clk_i, .rstn_i, .psel_i, .penable_i, .pwrite_i,
		.paddr_i, .pwdata_i, .pstrb_i, .prdata_o, .pready_o, .pslverr_o, .osc_in_pin_i,
		.osc_pins_detach_o, .osc_ext_clock_o, .compare_out_a_o, .compare_out_b_o,
		.out_a_override_o, .out_b_override_o, .overflow_flag_o, .match_a_o, .match_b_o);

	always #2 clk_i = ~clk_i;
	// ************************************************************
	// oscillator pin: period of ten system clocks
	// ************************************************************
	always @(posedge clk_i) begin
		osc_cnt <= (osc_cnt == 3'h4) ? 3'h0 : osc_cnt + 3'h1;
		if (osc_cnt == 3'h4) begin
			osc_in_pin_i <= ~osc_in_pin_i;
		end
	end
	// free-running high-time and toggle counts of both outputs
	always @(posedge clk_i) begin
		cnt[0] <= cnt[0] + int'(compare_out_a_o);
		cnt[1] <= cnt[1] + int'(compare_out_b_o);
		cnt[2] <= cnt[2] + int'(compare_out_a_o ^ last[0]);
		cnt[3] <= cnt[3] + int'(compare_out_b_o ^ last[1]);
		cnt[4] <= cnt[4] + int'(overflow_flag_o);
		cnt[5] <= cnt[5] + int'(match_a_o) + int'(match_b_o);
		last <= {compare_out_b_o, compare_out_a_o};
	end
	// ************************************************************
	// helpers
	// ************************************************************
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	function automatic logic [7:0] rnd8();
		logic [31:0] r;
		r = rnd();
		return r[7:0];
	endfunction
	function automatic logic [7:0] mask(logic [7:0] a);
		return a == 8'hb0 ? 8'hf3 : a == 8'hb1 ? 8'h0f : a == 8'hb6 ? 8'h60 : a == 8'hc0 ? 8'h00 : 8'hff;
	endfunction
	// high cycles per period: fast pwm period 256, phase correct 510
	function automatic int exp_hi(logic fast, logic [1:0] com, logic [7:0] c);
		int h;
		h = fast ? int'(c) + 1 : 2 * int'(c);
		return com == 2'h3 ? (fast ? 256 : 510) - h : h;
	endfunction
	task automatic chk(input logic [32:0] got, input logic [32:0] exp);
		n_tests++;
		if (got !== exp) begin
			fails++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// one transfer; ready, read data and error are all taken at the access edge
	task automatic apb(input logic wt, input logic [7:0] a, input logic [7:0] dt);
		int n;
		logic [31:0] r;
		n = 0;
		r = rnd();
		@(posedge clk_i);
		psel_i <= 1'b1;
		pwrite_i <= wt;
		paddr_i <= {24'h0, a};
		pwdata_i <= {r[31:8], dt};
		@(posedge clk_i);
		penable_i <= 1'b1;
		do begin
			@(posedge clk_i);
			n++;
		end while (pready_o !== 1'b1 && n < 16);
		rd = prdata_o;
		er = pslverr_o;
		if (pready_o !== 1'b1) fails++;
		psel_i <= 1'b0;
		penable_i <= 1'b0;
	endtask
	task automatic span(input int len);
		int s [6];
		@(negedge clk_i);
		s = cnt;
		repeat (len) @(negedge clk_i);
		foreach (d4[i]) d4[i] = cnt[i] - s[i];
	endtask
	task automatic results();
		$display("comparisons %0d mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	initial begin
		// about twice the length of all tests together
		repeat (60000) @(posedge clk_i);
		fails++;
		results();
	end
	// ************************************************************
	// tests
	// ************************************************************
	initial begin
		repeat (16) @(posedge clk_i);
		rstn_i <= 1'b1;
		foreach (amap[i]) begin
			apb(1'b0, amap[i], 8'h00);
			chk({er, rd}, 33'h0);
			for (int k = 0; k < 8; k++) begin
				d = rnd8();
				apb(1'b1, amap[i], d);
				apb(1'b0, amap[i], 8'h00);
				chk(rd, {24'h0, d & mask(amap[i])});
			end
		end
		apb(1'b1, 8'hb3, 8'h5a);
		pstrb_i <= 4'he;
		apb(1'b1, 8'hb3, 8'ha5);
		pstrb_i <= 4'hf;
		apb(1'b0, 8'hb3, 8'h00);
		chk(rd, 32'h5a);
		apb(1'b1, 8'ha0, 8'h11);
		apb(1'b0, 8'ha0, 8'h00);
		chk({er, rd}, 33'h100000000);
		$display("test registers done");
		foreach (avals[i]) begin
			apb(1'b1, 8'hb6, avals[i]);
			@(negedge clk_i);
			chk({osc_pins_detach_o, osc_ext_clock_o}, {avals[i][5], avals[i][5] & avals[i][6]});
		end
		$display("test oscillator pins done");
		apb(1'b1, 8'hb0, 8'h00);
		for (int s = 0; s < 2; s++) begin
			apb(1'b1, 8'hb6, s ? 8'h20 : 8'h00);
			for (int c = 0; c < (s ? 3 : 8); c++) begin
				apb(1'b1, 8'hb1, 8'(c));
				apb(1'b1, 8'hc0, 8'h02);
				apb(1'b1, 8'hb2, 8'h00);
				apb(1'b0, 8'hb2, 8'h00);
				v = rd;
				w = (c == 0) ? 20 : 4 * dv[c] * (s ? 10 : 1);
				repeat (w - 3) @(posedge clk_i);
				apb(1'b0, 8'hb2, 8'h00);
				chk(rd - v, (c == 0) ? 32'h0 : 32'h4);
			end
		end
		apb(1'b1, 8'hb6, 8'h00);
		$display("test prescaler done");
		// undivided system clock: one tick per cycle, so a normal or fast pwm period is 256 cycles
		apb(1'b1, 8'hb1, 8'h01);
		for (int m = 0; m < 4; m++) begin
			apb(1'b1, 8'hb3, rnd8());
			apb(1'b1, 8'hb4, rnd8());
			apb(1'b1, 8'hb0, 8'(m * 8'h50));
			span(300);
			span(512);
			e = (m == 1) ? 2 : ((m == 3) ? 512 : 0);
			chk(d4[m == 1 ? 2 : 0], e);
			chk(d4[m == 1 ? 3 : 1], e);
			chk({out_a_override_o, out_b_override_o}, (m != 0) ? 2'h3 : 2'h0);
			chk(d4[4], 2);
			chk(d4[5], 4);
		end
		$display("test non-pwm outputs done");
		for (int k = 0; k < 4; k++) begin
			ca = (k == 0) ? 8'h00 : ((k == 1) ? 8'hff : rnd8());
			cb = (k < 2) ? ~ca : rnd8();
			foreach (pw[i]) begin
				apb(1'b1, 8'hb3, ca);
				apb(1'b1, 8'hb4, cb);
				apb(1'b1, 8'hb0, pw[i]);
				span(600);
				span(pw[i][1] ? 256 : 510);
				chk(d4[0], exp_hi(pw[i][1], pw[i][7:6], ca));
				chk(d4[1], exp_hi(pw[i][1], pw[i][5:4], cb));
				chk(d4[4], 1);
			end
		end
		$display("test pwm outputs done");
		results();
	end
endmodule
